//--- core/ict_target.sv
// target end: i2c register port with general config and gain registers
// assumes scl/sda synchronous to ref_clk and straps stable while srst is high
//
// Contract
// - strap pins pick seven-bit target address
// - write: start, address, zero bit, acked
// - pointer byte after address, acked
// - every written data byte is acked
// - controller ends each write with stop
// - read: start, address, one bit, acked
// - reads start at pointer, msb first
// - controller ack sends next byte, nack ends
// - controller ends read with stop
// - pointer-only write sets next read start
// - reads default from 00h, auto-increment
// - general register at 0x0a, resets 01
// - bit2 is orientation swap, reset zero
// - bits1:0 link control, reset 01
// - updated fields read live hardware value
// - link 01 routes by swap, 00 off
// - gain registers offer same sixteen settings
//
// Implementation choice: the APB interface to the registers.
`default_nettype none
`include "ict_map.svh"

module ict_target #(
  parameter int PTR_W = 8
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            srst,
  // two-wire bus
  ict_if.target                bus,
  // straps, four-level address codes and four-bit gains
  input  wire ict_pkg::ict_lvl_t addr_strap_hi,
  input  wire ict_pkg::ict_lvl_t addr_strap_lo,
  input  wire logic [3:0]      down_lane1_strap,
  input  wire logic [3:0]      down_lane2_strap,
  input  wire logic [3:0]      up_lane_strap,
  // configuration to datapath
  output logic                 eq_source_select,
  output logic                 orientation_swap,
  output logic [1:0]           link_enable_select,
  output logic                 link_power_down,
  output logic                 route_flipped,
  output logic [3:0]           down_lane1_gain,
  output logic [3:0]           down_lane2_gain,
  output logic [3:0]           up_lane_gain
);
  import ict_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  generate
    if (PTR_W != 8) begin : g_bad_ptr
      $error("ict_target: pointer must be one byte");
    end
  endgenerate

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam ict_byte_t GEN_RST = `ICT_GEN_RST;  // reset image, so its fields can be sliced
  ict_tgt_state_t state;
  logic           scl_q;
  logic           sda_q;
  logic [2:0]     bitcnt;
  ict_byte_t      shreg;
  ict_byte_t      tx;
  logic           rw;
  logic           ptr_phase;
  logic           ack_on;
  logic           sda_oe_n;
  logic           sda_o;
  ict_byte_t      ptr;
  logic           wr_stb;
  ict_byte_t      wr_ofs;
  ict_byte_t      wr_data;
  ict_lvl_t       strap_hi;
  ict_lvl_t       strap_lo;
  logic [3:0]     strap_d1;
  logic [3:0]     strap_d2;
  logic [3:0]     strap_up;
  logic           gen_src;
  logic           gen_swap;
  logic [1:0]     gen_link;
  logic [3:0]     prog_d1;
  logic [3:0]     prog_d2;
  logic [3:0]     prog_up;
  logic [3:0]     live_d1;
  logic [3:0]     live_d2;
  logic [3:0]     live_up;
  logic [6:0]     own_addr;
  logic [4:0]     addr_pfx;
  ict_byte_t      rd_val;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_cond;
  logic           stop_cond;

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  // previous line levels
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  // edges and start/stop framing
  assign scl_rise   = bus.scl && !scl_q;
  assign scl_fall   = !bus.scl && scl_q;
  assign start_cond = bus.scl && scl_q && sda_q && !bus.sda;
  assign stop_cond  = bus.scl && scl_q && !sda_q && bus.sda;

  // ----------------------------------------------------------------
  // straps and own address
  // ----------------------------------------------------------------
  // straps latched while reset is held
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      strap_hi <= addr_strap_hi;
      strap_lo <= addr_strap_lo;
      strap_d1 <= down_lane1_strap;
      strap_d2 <= down_lane2_strap;
      strap_up <= up_lane_strap;
    end
  end

  // upper address bits from high strap level
  always_comb begin
    if (strap_hi == `ICT_LVL_0) begin
      addr_pfx = `ICT_PFX_0;
    end else if (strap_hi == `ICT_LVL_R) begin
      addr_pfx = `ICT_PFX_R;
    end else if (strap_hi == `ICT_LVL_F) begin
      addr_pfx = `ICT_PFX_F;
    end else begin
      addr_pfx = `ICT_PFX_1;
    end
  end
  assign own_addr = {addr_pfx, strap_lo};

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // writes from the bus engine
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gen_src  <= GEN_RST[`ICT_GEN_SRC_BIT];
      gen_swap <= GEN_RST[`ICT_GEN_SWAP_BIT];
      gen_link <= GEN_RST[`ICT_GEN_LINK_HI:`ICT_GEN_LINK_LO];
      prog_d1  <= 4'h0;
      prog_d2  <= 4'h0;
      prog_up  <= 4'h0;
    end else if (wr_stb) begin
      if (wr_ofs == `ICT_GEN_OFS) begin
        gen_src  <= wr_data[`ICT_GEN_SRC_BIT];  // reserved bits dropped
        gen_swap <= wr_data[`ICT_GEN_SWAP_BIT];
        gen_link <= wr_data[`ICT_GEN_LINK_HI:`ICT_GEN_LINK_LO];
      end else if (wr_ofs == `ICT_EQD_OFS) begin
        prog_d2 <= wr_data[7:4];
        prog_d1 <= wr_data[3:0];
      end else if (wr_ofs == `ICT_EQU_OFS) begin
        prog_up <= wr_data[3:0];
      end
    end
  end

  // live gains: straps or programmed values
  assign live_d1 = gen_src ? prog_d1 : strap_d1;
  assign live_d2 = gen_src ? prog_d2 : strap_d2;
  assign live_up = gen_src ? prog_up : strap_up;

  // read mux, unmapped reads zero
  always_comb begin
    if (ptr == `ICT_GEN_OFS) begin
      rd_val = {3'h0, gen_src, 1'b0, gen_swap, gen_link};
    end else if (ptr == `ICT_EQD_OFS) begin
      rd_val = {live_d2, live_d1};
    end else if (ptr == `ICT_EQU_OFS) begin
      rd_val = {4'h0, live_up};
    end else begin
      rd_val = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // bus engine
  // ----------------------------------------------------------------
  // byte framing, acknowledge and pointer handling
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state     <= ST_IDLE;
      bitcnt    <= 3'h0;
      shreg     <= 8'h00;
      tx        <= 8'h00;
      rw        <= 1'b0;
      ptr_phase <= 1'b0;
      ack_on    <= 1'b0;
      sda_oe_n  <= 1'b1;
      ptr       <= `ICT_PTR_RST;
      wr_stb    <= 1'b0;
      wr_ofs    <= 8'h00;
      wr_data   <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_cond) begin
        state    <= ST_ADDR;
        bitcnt   <= 3'h0;
        sda_oe_n <= 1'b1;
        ack_on   <= 1'b0;
      end else if (stop_cond) begin
        state    <= ST_IDLE;
        sda_oe_n <= 1'b1;
        ack_on   <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            bitcnt <= 3'h0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], bus.sda};
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == 3'h7) begin
                if (shreg[6:0] == own_addr) begin
                  rw        <= bus.sda;
                  ptr_phase <= !bus.sda;
                  state     <= ST_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!ack_on) begin
                ack_on   <= 1'b1;
                sda_oe_n <= 1'b0;
              end else begin
                ack_on <= 1'b0;
                bitcnt <= 3'h0;
                if (rw) begin
                  state    <= ST_RBYTE;
                  sda_oe_n <= rd_val[7];
                  tx       <= {rd_val[6:0], 1'b0};
                end else begin
                  state    <= ST_WBYTE;
                  sda_oe_n <= 1'b1;
                end
              end
            end
          end
          ST_WBYTE: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], bus.sda};
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == 3'h7) begin
                state <= ST_ACK;
                if (ptr_phase) begin
                  ptr       <= {shreg[6:0], bus.sda};
                  ptr_phase <= 1'b0;
                end else begin
                  wr_stb  <= 1'b1;
                  wr_ofs  <= ptr;
                  wr_data <= {shreg[6:0], bus.sda};
                  ptr     <= ptr + 8'h01;
                end
              end
            end
          end
          ST_RBYTE: begin
            if (scl_fall) begin
              sda_oe_n <= tx[7];
              tx       <= {tx[6:0], 1'b0};
            end else if (scl_rise) begin
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == 3'h7) begin
                state <= ST_RACK;
                ptr   <= ptr + 8'h01;
              end
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
            end else if (scl_rise) begin
              bitcnt <= 3'h0;
              if (!bus.sda) begin
                state <= ST_RBYTE;
                tx    <= rd_val;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // open-drain data pin, value always low
  always_ff @(posedge ref_clk) begin
    sda_o <= 1'b0;
  end
  assign bus.dev_sda_o    = sda_o;
  assign bus.dev_sda_oe_n = sda_oe_n;

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  // registered view of config and routing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      eq_source_select   <= 1'b0;
      orientation_swap   <= 1'b0;
      link_enable_select <= `ICT_LINK_ON;
      link_power_down    <= 1'b0;
      route_flipped      <= 1'b0;
      down_lane1_gain    <= 4'h0;
      down_lane2_gain    <= 4'h0;
      up_lane_gain       <= 4'h0;
    end else begin
      eq_source_select   <= gen_src;
      orientation_swap   <= gen_swap;
      link_enable_select <= gen_link;
      link_power_down    <= (gen_link != `ICT_LINK_ON);
      route_flipped      <= (gen_link == `ICT_LINK_ON) && gen_swap;
      down_lane1_gain    <= live_d1;
      down_lane2_gain    <= live_d2;
      up_lane_gain       <= live_up;
    end
  end

endmodule : ict_target

`default_nettype wire

//--- core/ict_map.svh
// offsets, field positions, reset values and timing figures of the i2c config target
// assumes nothing; definitions only, included by bare name
`ifndef ICT_MAP_SVH
`define ICT_MAP_SVH

// ----------------------------------------------------------------
// target register map
// ----------------------------------------------------------------
`define ICT_GEN_OFS        8'h0a
`define ICT_EQD_OFS        8'h20
`define ICT_EQU_OFS        8'h21
`define ICT_GEN_RST        8'h01
`define ICT_GEN_SRC_BIT    4
`define ICT_GEN_SWAP_BIT   2
`define ICT_GEN_LINK_HI    1
`define ICT_GEN_LINK_LO    0
`define ICT_LINK_OFF       2'h0
`define ICT_LINK_ON        2'h1
`define ICT_PTR_RST        8'h00

// ----------------------------------------------------------------
// four-level strap encoding and address prefixes
// ----------------------------------------------------------------
`define ICT_LVL_0          2'h0
`define ICT_LVL_R          2'h1
`define ICT_LVL_F          2'h2
`define ICT_LVL_1          2'h3
`define ICT_PFX_0          5'h11
`define ICT_PFX_R          5'h08
`define ICT_PFX_F          5'h04
`define ICT_PFX_1          5'h03

// ----------------------------------------------------------------
// controller apb map
// ----------------------------------------------------------------
`define ICT_APB_CMD        8'h00
`define ICT_APB_TADDR      8'h04
`define ICT_APB_PTR        8'h08
`define ICT_APB_WDATA      8'h0c
`define ICT_APB_STATUS     8'h10
`define ICT_CMD_GO_BIT     0
`define ICT_CMD_RD_BIT     1
`define ICT_CMD_DATA_BIT   2
`define ICT_TADDR_RST      7'h44

// ----------------------------------------------------------------
// bus timing
// ----------------------------------------------------------------
`define ICT_SCL_PERIOD_NS  10000
`define ICT_CLK_PERIOD_NS  25

`endif

//--- core/ict_pkg.sv
// types shared by both ends of the i2c config target
// assumes ict_map.svh supplies the numeric constants
`default_nettype none

package ict_pkg;
  typedef logic [1:0] ict_lvl_t;
  typedef logic [7:0] ict_byte_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WBYTE, ST_RBYTE, ST_RACK} ict_tgt_state_t;
  typedef enum logic [1:0] {C_IDLE, C_START, C_BIT, C_STOP} ict_ctl_state_t;
endpackage : ict_pkg

`default_nettype wire

//--- core/ict_if.sv
// two-wire bus between controller end and target end
// assumes pull-ups: a line is low only while some end drives it low
`default_nettype none

interface ict_if;
  // controller drives
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  // target drives
  logic dev_sda_o;
  logic dev_sda_oe_n;
  // resolved wire levels
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = (!host_scl_oe_n && !host_scl_o) ? 1'b0 : 1'b1;
  assign sda = ((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o)) ? 1'b0 : 1'b1;

  modport target (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport ctrl (input scl, input sda, output host_scl_o, output host_scl_oe_n, output host_sda_o,
                output host_sda_oe_n);
endinterface : ict_if

`default_nettype wire

//--- core/ict_ctrl.sv
// controller end: apb-programmed i2c controller for the config target
// assumes apb master on ref_clk; target never stretches scl
`default_nettype none
`include "ict_map.svh"

module ict_ctrl #(
  parameter int QTR_CYCLES = ((`ICT_SCL_PERIOD_NS / 4) + `ICT_CLK_PERIOD_NS - 1) / `ICT_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // two-wire bus
  ict_if.ctrl              bus
);
  import ict_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  generate
    if (QTR_CYCLES < 2 || QTR_CYCLES > 65535) begin : g_bad_qtr
      $error("ict_ctrl: quarter period out of range");
    end
  endgenerate

  ict_ctl_state_t state;
  logic           go;
  logic           cmd_rd;
  logic           cmd_data;
  logic [6:0]     taddr;
  ict_byte_t      ptr_byte;
  ict_byte_t      wdata;
  logic           busy;
  logic           nack;
  ict_byte_t      rdata;
  logic [15:0]    qcnt;
  logic           tick;
  logic [1:0]     qph;
  logic [3:0]     bitn;
  logic [1:0]     fidx;
  logic [1:0]     nfr;
  logic           is_rd;
  logic [8:0]     frame;
  logic [8:0]     rx;
  logic           scl_oe_n;
  logic           sda_oe_n;
  logic           pin_o;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // two-cycle access, error on unmapped address
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
      go       <= 1'b0;
      cmd_rd   <= 1'b0;
      cmd_data <= 1'b0;
      taddr    <= `ICT_TADDR_RST;
      ptr_byte <= 8'h00;
      wdata    <= 8'h00;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      go      <= 1'b0;
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= 32'h0;
        if (paddr == `ICT_APB_CMD) begin
          if (pwrite) begin
            go       <= pwdata[`ICT_CMD_GO_BIT] && !busy;
            cmd_rd   <= pwdata[`ICT_CMD_RD_BIT];
            cmd_data <= pwdata[`ICT_CMD_DATA_BIT];
          end else begin
            prdata <= {29'h0, cmd_data, cmd_rd, 1'b0};
          end
        end else if (paddr == `ICT_APB_TADDR) begin
          if (pwrite) taddr <= pwdata[6:0];
          else prdata <= {25'h0, taddr};
        end else if (paddr == `ICT_APB_PTR) begin
          if (pwrite) ptr_byte <= pwdata[7:0];
          else prdata <= {24'h0, ptr_byte};
        end else if (paddr == `ICT_APB_WDATA) begin
          if (pwrite) wdata <= pwdata[7:0];
          else prdata <= {24'h0, wdata};
        end else if (paddr == `ICT_APB_STATUS) begin
          if (!pwrite) prdata <= {16'h0, rdata, 6'h0, nack, busy};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  // quarter-bit tick, realigned on each command
  always_ff @(posedge ref_clk) begin
    if (srst || go || tick) begin
      qcnt <= 16'h0;
    end else begin
      qcnt <= qcnt + 16'h1;
    end
  end
  assign tick = (qcnt == 16'(QTR_CYCLES - 1));

  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  // start, frames of nine bits, stop
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state    <= C_IDLE;
      busy     <= 1'b0;
      nack     <= 1'b0;
      rdata    <= 8'h00;
      qph      <= 2'h0;
      bitn     <= 4'h0;
      fidx     <= 2'h0;
      nfr      <= 2'h0;
      is_rd    <= 1'b0;
      frame    <= 9'h1ff;
      rx       <= 9'h0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (state == C_IDLE) begin
      if (go) begin
        state <= C_START;
        busy  <= 1'b1;
        nack  <= 1'b0;
        qph   <= 2'h0;
        bitn  <= 4'h0;
        fidx  <= 2'h0;
        is_rd <= cmd_rd;
        nfr   <= (cmd_rd || !cmd_data) ? 2'h2 : 2'h3;  // pointer-only write
        frame <= {taddr, cmd_rd, 1'b1};
      end
    end else if (tick) begin
      qph <= qph + 2'h1;
      case (state)
        C_START: begin
          if (qph == 2'h1) sda_oe_n <= 1'b0;
          if (qph == 2'h2) scl_oe_n <= 1'b0;
          if (qph == 2'h3) state <= C_BIT;
        end
        C_BIT: begin
          if (qph == 2'h0) sda_oe_n <= frame[8];  // msb first
          if (qph == 2'h1) scl_oe_n <= 1'b1;
          if (qph == 2'h2) rx <= {rx[7:0], bus.sda};
          if (qph == 2'h3) begin
            scl_oe_n <= 1'b0;
            frame    <= {frame[7:0], 1'b1};
            bitn     <= bitn + 4'h1;
            if (bitn == 4'h8) begin
              bitn <= 4'h0;
              fidx <= fidx + 2'h1;
              if (is_rd && fidx == 2'h1) begin
                rdata <= rx[8:1];  // nack after one byte
                state <= C_STOP;
              end else if (rx[0]) begin
                nack  <= 1'b1;
                state <= C_STOP;
              end else if (fidx + 2'h1 == nfr) begin
                state <= C_STOP;
              end else if (is_rd) begin
                frame <= 9'h1ff;
              end else if (fidx == 2'h0) begin
                frame <= {ptr_byte, 1'b1};
              end else begin
                frame <= {wdata, 1'b1};
              end
            end
          end
        end
        C_STOP: begin
          if (qph == 2'h0) sda_oe_n <= 1'b0;
          if (qph == 2'h1) scl_oe_n <= 1'b1;
          if (qph == 2'h2) sda_oe_n <= 1'b1;
          if (qph == 2'h3) begin
            state <= C_IDLE;
            busy  <= 1'b0;
          end
        end
        default: begin
          state <= C_IDLE;
        end
      endcase
    end
  end

  // open-drain pins, value always low
  always_ff @(posedge ref_clk) begin
    pin_o <= 1'b0;
  end
  assign bus.host_scl_o    = pin_o;
  assign bus.host_sda_o    = pin_o;
  assign bus.host_scl_oe_n = scl_oe_n;
  assign bus.host_sda_oe_n = sda_oe_n;

endmodule : ict_ctrl

`default_nettype wire

//--- bench/ict_checker_assertions.sv
// checker on the shared two-wire lines
// assumes the bench wires it to the interface beside both ends
`default_nettype none
module ict_checker (
  // clock, reset, lines
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [3:0] n;
  logic       f, rd, ak;
  // bit slot, first frame, direction, address acked
  always_ff @(posedge ref_clk) begin
    if (srst || (scl && $fell(sda))) begin
      n <= 4'h0;
      f <= 1'b1;
      rd <= 1'b0;
      ak <= 1'b0;
    end else if ($rose(scl)) begin
      n <= (n == 4'h8) ? 4'h0 : n + 4'h1;
      if (f && n == 4'h7) rd <= sda;
      if (f && n == 4'h8) ak <= !sda;
      if (n == 4'h8) f <= rd && !f;
    end
  end
  // --------
  // wire rules
  // --------
  dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("target moved sda with scl high");
  host_start_a: assert property (scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe_n))
    else $error("start or stop not from controller");
  addr_quiet_a: assert property ($rose(scl) && (f || !rd) && n != 4'h8 |-> dev_sda_oe_n)
    else $error("target drove a controller bit");
  ack_slot_a: assert property ($rose(scl) && (f || !rd) && n == 4'h8 |-> host_sda_oe_n)
    else $error("controller held ack slot");
  wr_ack_a: assert property ($rose(scl) && !f && !rd && ak && n == 4'h8 |-> !dev_sda_oe_n)
    else $error("written byte not acked");
  rd_drive_a: assert property ($rose(scl) && !f && rd && ak && n != 4'h8 |-> host_sda_oe_n)
    else $error("controller drove read data");
  rd_nack_a: assert property ($rose(scl) && !f && rd && ak && n == 4'h8 |-> dev_sda_oe_n)
    else $error("target held sda in ack slot");
  stop_idle_a: assert property (scl && $rose(sda) |-> dev_sda_oe_n)
    else $error("target busy at stop");
endmodule // ict_checker
`default_nettype wire

//--- bench/test_i2c_config_target.sv
// bench: apb-driven controller end talks to the target end
// assumes 40 MHz ref_clk and shortened bit quarters
`default_nettype none
`include "ict_map.svh"
module test_i2c_config_target;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, v;
  logic [31:0] pwdata = 32'h0, prdata, st, q, w, seed = 32'd54013;
  logic        pready, pslverr, se, src, swp, pd, fl;
  logic [1:0]  hi, lo, lk;
  logic [3:0]  s1, s2, su, g1, g2, gu;
  int          fail_count = 0, checks = 0, cyc = 0;
  ict_if bus_if ();
  ict_ctrl #(.QTR_CYCLES(4)) u_ict_ctrl (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus(bus_if.ctrl));
  ict_target u_ict_target (.ref_clk, .srst, .bus(bus_if.target), .addr_strap_hi(hi), .addr_strap_lo(lo),
    .down_lane1_strap(s1), .down_lane2_strap(s2), .up_lane_strap(su), .eq_source_select(src),
    .orientation_swap(swp), .link_enable_select(lk), .link_power_down(pd), .route_flipped(fl),
    .down_lane1_gain(g1), .down_lane2_gain(g2), .up_lane_gain(gu));
  ict_checker u_chk (.ref_clk, .srst, .scl(bus_if.scl), .sda(bus_if.sda), .host_scl_oe_n(bus_if.host_scl_oe_n),
    .host_sda_oe_n(bus_if.host_sda_oe_n), .dev_sda_oe_n(bus_if.dev_sda_oe_n));
  initial forever #12.5 ref_clk = ~ref_clk;
  // hang guard
  always @(posedge ref_clk) if (++cyc == 90000) begin
    fail_count++;
    final_report();
  end
  // --------
  // helpers
  // --------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [6:0] ta(input logic [1:0] h, l);
    return {(h == 0) ? 5'h11 : (h == 1) ? 5'h08 : (h == 2) ? 5'h04 : 5'h03, l};
  endfunction
  task automatic chk(input logic [31:0] s, e, input string m);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer, read data into q, error flag into se, both taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one bus transaction, status into st
  task automatic op(input logic r, dt, input logic [7:0] p, d);
    apb(1, `ICT_APB_PTR, {24'h0, p});
    apb(1, `ICT_APB_WDATA, {24'h0, d});
    apb(1, `ICT_APB_CMD, {29'h0, dt, r, 1'b1});
    do apb(0, `ICT_APB_STATUS, 0); while (q[0] !== 1'b0);
    st = q;
  endtask
  // --------
  // main sequence
  // --------
  initial begin
    w = xs();
    {hi, lo, s1, s2, su} <= w[15:0];
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({src, swp, lk}, 4'h1, "config reset");
    apb(1, `ICT_APB_TADDR, {25'h0, ta(hi, lo) ^ 7'h01});
    op(1, 0, 0, 0);
    chk(st[1], 1'b1, "foreign address acked");
    apb(1, `ICT_APB_TADDR, {25'h0, ta(hi, lo)});
    op(0, 0, `ICT_GEN_OFS, 0);
    op(1, 0, 0, 0);
    chk(st[15:8], 8'h01, "general reset");
    apb(0, 8'h14, 0);
    chk(se, 1'b1, "unmapped apb not refused");
    chk(q, 32'h0, "unmapped apb read data");
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      w = xs();
      v = {w[7:2], k[1:0]};
      op(0, 1, `ICT_GEN_OFS, v);
      chk(st[1], 1'b0, "data byte refused");
      op(0, 1, `ICT_EQD_OFS, w[15:8]);
      op(0, 1, `ICT_EQU_OFS, w[23:16]);
      op(0, 0, 8'h1f, 0);
      op(1, 0, 0, 0);
      chk(st[15:8], 8'h00, "unmapped read");
      op(1, 0, 0, 0);
      chk(st[15:8], v[4] ? w[15:8] : {s2, s1}, "down gains");
      op(1, 0, 0, 0);
      chk(st[15:8], {4'h0, v[4] ? w[19:16] : su}, "up gain");
      op(0, 0, `ICT_GEN_OFS, 0);
      op(1, 0, 0, 0);
      chk(st[15:8], v & 8'h17, "general");
      chk({swp, lk, pd, fl}, {v[2], v[1:0], v[1:0] != 2'h1, v[1:0] == 2'h1 && v[2]}, "routing");
      chk({src, g2, g1, gu}, {v[4], v[4] ? {w[15:8], w[19:16]} : {s2, s1, su}}, "gains");
      $display("pass %0d done", k);
    end
    final_report();
  end
endmodule // test_i2c_config_target
`default_nettype wire
